// *** verilog/fsmon_regs.vh ***
// register map, field positions, reset values and timing for the fan speed monitor
//
// Function
// - low byte read freezes high byte
// - fast select updates every 250ms, else 1s
// - pulse select: one means four, zero two
// - power mode clear keeps drive on measuring
// - power mode set: no forcing, always update
// - regulation mode with power mode clear floors duty at 30%
// - other modes, power mode clear: under 7% gives 0%, no update
// - period above slow limit sets slow flag
// - no slow detection during spin-up
// - slow flag clears on read, set after spin-up
// - overspeed flag, read clears, rearm after recovery
// - range events pull alert low if enabled
// - slow fan starts timed spin-up, remeasure after
// - five failed spin-ups declare fan failure
// - recovery before fifth keeps failure output released
// - failure keeps retrying; recovery releases failure
// - failure pin open drain, gated by enable
// - overtemp pin low until 5C under limit and flags read
// - overtemp flags set, pin forced, alert if enabled
// - read clears overtemp flags, rearm after hysteresis
// - full speed enable: driven pin forces 100%
// - external low on pin: flag and 100%
// - period counted at 100kHz, saturates at 16 bits
// - monitoring needs start and measurement enable
`ifndef FSMON_REGS_VH
`define FSMON_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define FSMON_OFS_CFG       8'h00
`define FSMON_OFS_DUTY      8'h04
`define FSMON_OFS_SPD_LO    8'h08
`define FSMON_OFS_SPD_HI    8'h0C
`define FSMON_OFS_LOW_LIM   8'h10
`define FSMON_OFS_HIGH_LIM  8'h14
`define FSMON_OFS_STATUS    8'h18
`define FSMON_OFS_OT_LIM    8'h1C
`define FSMON_OFS_DUTY_OUT  8'h20

// ****************************************
// configuration fields
// ****************************************
`define FSMON_CFG_START     0
`define FSMON_CFG_TACH_EN   1
`define FSMON_CFG_PWR_MODE  2
`define FSMON_CFG_FAST      3
`define FSMON_CFG_PULSES_PER_REV_SEL      4
`define FSMON_CFG_FAN_RANGE_IRQ_EN     5
`define FSMON_CFG_OTIE      6
`define FSMON_CFG_OTFS      7
`define FSMON_CFG_FAULT_EN  8
`define FSMON_CFG_SPIN_DIS  9
`define FSMON_CFG_MODE_LO   10
`define FSMON_CFG_STIME_LO  12
`define FSMON_CFG_RST       16'h5800

// ****************************************
// status fields
// ****************************************
`define FSMON_ST_SLOW       0
`define FSMON_ST_OVS        1
`define FSMON_ST_ROT        2
`define FSMON_ST_LOT        3
`define FSMON_ST_EXT        4
`define FSMON_ST_FAIL       5

// ****************************************
// reset values and constants
// ****************************************
`define FSMON_LOW_LIM_RST   16'hFFFF
`define FSMON_HIGH_LIM_RST  16'h0000
`define FSMON_OT_LIM_RST    16'h6464
`define FSMON_MODE_REG      2'h1
`define FSMON_DUTY_30       8'h4D
`define FSMON_DUTY_7        8'h12
`define FSMON_DUTY_FULL     8'hFF
`define FSMON_OT_HYST       9'h005
`define FSMON_SPIN_TRIES    3'h5

// ****************************************
// timing
// ****************************************
`define FSMON_CLK_HZ        200000000
`define FSMON_BASE_HZ       100000
`define FSMON_TICK_DIV      (`FSMON_CLK_HZ / `FSMON_BASE_HZ)
`define FSMON_MON_SLOW_MS   1000
`define FSMON_MON_FAST_MS   250
`define FSMON_SPIN_UNIT_MS  200
`define FSMON_MS_TICKS(ms)  ((ms) * (`FSMON_BASE_HZ / 1000))

`endif

// *** verilog/fsmon_sync2.v ***
// two-flop synchroniser for asynchronous pin inputs
`default_nettype none

module fsmon_sync2 #(
	parameter         W       = 2,
	parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
	input  wire         ref_clk,
	input  wire         rst_n,
	input  wire         ce,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);

	reg [W-1:0] meta; // first stage, read only by q

	// ****************************************
	// two stages; reset to the pins' idle level
	// ****************************************
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= RST_VAL;
			q    <= RST_VAL;
		end else if (ce) begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

`default_nettype wire

// *** verilog/fsmon_top.v ***
// fan speed monitor: period readout, slow/overspeed alarms, spin-up and overtemp pin
`default_nettype none
`include "fsmon_regs.vh"

module fsmon_top #(
	parameter MON_SLOW_TICKS  = `FSMON_MS_TICKS(`FSMON_MON_SLOW_MS),
	parameter MON_FAST_TICKS  = `FSMON_MS_TICKS(`FSMON_MON_FAST_MS),
	parameter SPIN_UNIT_TICKS = `FSMON_MS_TICKS(`FSMON_SPIN_UNIT_MS)
) (
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire        ce,
	input  wire [7:0]  wb_adr_i,
	input  wire [31:0] wb_dat_i,
	input  wire [3:0]  wb_sel_i,
	input  wire        wb_we_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        tach_i,
	input  wire [7:0]  remote_temp,
	input  wire [7:0]  local_temp,
	input  wire        overtemp_pin_i,
	output reg         overtemp_pin_o,
	output reg         overtemp_pin_oe_n,
	output reg         fault_o,
	output reg         fault_oe_n,
	output reg         alert_o,
	output reg         alert_oe_n,
	output reg  [7:0]  duty_out,
	output reg         force_on,
	output reg         spinup_active
);

	localparam integer TICK_DIV_FULL = `FSMON_TICK_DIV;
	localparam [11:0]  TICK_DIV      = TICK_DIV_FULL[11:0]; // 2000 fits in 12 bits
	// measurement states, one-hot
	localparam [2:0] M_WAIT = 3'h1;
	localparam [2:0] M_CNT  = 3'h2;
	localparam [2:0] M_DONE = 3'h4;

	// ****************************************
	// helper functions
	// ****************************************
	// byte-lane write merge
	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  sel;
		integer      i;
		begin
			wmerge = old;
			for (i = 0; i < 4; i = i + 1)
				if (sel[i])
					wmerge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction

	// spin-up length in 0.2 s units
	function [5:0] spin_units;
		input [2:0] s;
		begin
			case (s)
				3'h0: spin_units = 6'h01;
				3'h1: spin_units = 6'h02;
				3'h2: spin_units = 6'h03;
				3'h3: spin_units = 6'h04;
				3'h4: spin_units = 6'h05;
				3'h5: spin_units = 6'h0A;
				3'h6: spin_units = 6'h14;
				default: spin_units = 6'h28;
			endcase
		end
	endfunction

	// temperature above a limit (signed degrees)
	function ot_over;
		input [7:0] t;
		input [7:0] lim;
		begin
			ot_over = ($signed(t) > $signed(lim));
		end
	endfunction

	// temperature at least 5 degrees under a limit
	function ot_clear;
		input [7:0] t;
		input [7:0] lim;
		begin
			ot_clear = ($signed({t[7], t}) <= ($signed({lim[7], lim}) - $signed(`FSMON_OT_HYST)));
		end
	endfunction

	// ****************************************
	// registers and state
	// ****************************************
	reg  [15:0] cfg;           // configuration word
	reg  [7:0]  duty_cycle_setting; // duty requested by software, written over the bus
	reg  [15:0] low_lim;       // slow-speed threshold (period)
	reg  [15:0] high_lim;      // fast-speed threshold (period)
	reg  [15:0] ot_lims;       // [7:0] remote, [15:8] local
	reg  [15:0] speed_period;  // last stored period
	reg  [7:0]  hi_snap;       // high byte caught at low byte read
	reg         hi_frozen;     // high byte held until it is read
	reg         fan_slow;
	reg         overspeed_flag;
	reg         ovs_armed;     // overspeed may set again
	reg         remote_overtemp_flag;
	reg         local_overtemp_flag;
	reg         r_armed;
	reg         l_armed;
	reg         r_hold;        // remote over limit, with hysteresis
	reg         l_hold;        // local over limit, with hysteresis
	reg         fan_fail;
	reg  [2:0]  spin_tries;    // consecutive spin-ups without recovery
	reg  [11:0] div_cnt;       // 100 kHz tick divider
	reg         tick;
	reg  [19:0] mon_cnt;       // ticks into current monitoring cycle
	reg  [2:0]  meas_st;
	reg  [2:0]  edge_cnt;      // rising speed edges counted after the first one in the window
	reg  [15:0] per_cnt;       // period counter, saturating
	reg  [25:0] spin_cnt;      // ticks left in spin-up
	reg         tach_d;        // previous synced speed level
	reg         oe_d1;         // pin enable, one cycle late
	reg         oe_d2;         // pin enable, two cycles late
	wire [1:0]  sync_q;        // [0] speed, [1] overtemp pin

	// configuration decode
	wire        start     = cfg[`FSMON_CFG_START];
	wire        tach_en   = cfg[`FSMON_CFG_TACH_EN];
	wire        pwr_mode  = cfg[`FSMON_CFG_PWR_MODE];
	wire        fast_sel  = cfg[`FSMON_CFG_FAST];
	wire        pulses_per_rev_sel = cfg[`FSMON_CFG_PULSES_PER_REV_SEL];
	wire        fan_range_irq_en   = cfg[`FSMON_CFG_FAN_RANGE_IRQ_EN];
	wire        overtemp_irq_en    = cfg[`FSMON_CFG_OTIE];
	wire        overtemp_full_speed_en = cfg[`FSMON_CFG_OTFS];
	wire        fault_en  = cfg[`FSMON_CFG_FAULT_EN];
	wire        spin_en   = ~cfg[`FSMON_CFG_SPIN_DIS];
	wire [1:0]  fan_mode  = cfg[`FSMON_CFG_MODE_LO +: 2];
	wire [2:0]  spinup_time_sel = cfg[`FSMON_CFG_STIME_LO +: 3];

	// ****************************************
	// input synchroniser
	// ****************************************
	fsmon_sync2 #(
		.W       (2),
		.RST_VAL (2'h3)
	) u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.d       ({overtemp_pin_i, tach_i}),
		.q       (sync_q)
	);

	// ****************************************
	// combinational decode
	// ****************************************
	wire        monitoring = start & tach_en;
	wire        tach_rise  = sync_q[0] & ~tach_d;
	wire [2:0]  edge_tgt   = pulses_per_rev_sel ? 3'h4 : 3'h2;
	wire [19:0] mon_len    = fast_sel ? MON_FAST_TICKS[19:0] : MON_SLOW_TICKS[19:0];
	wire        mon_end    = monitoring & ~spinup_active & tick & (mon_cnt == mon_len - 20'h1);
	wire [15:0] result     = (meas_st == M_DONE) ? per_cnt : 16'hFFFF;
	wire        is_reg     = (fan_mode == `FSMON_MODE_REG);
	// under 7% outside regulation, with power mode clear, the update is dropped
	wire        low_duty   = ~pwr_mode & tach_en & ~is_reg &
	                         (duty_cycle_setting < `FSMON_DUTY_7);
	wire        upd        = mon_end & ~low_duty;
	wire        is_slow    = result > low_lim;
	wire        is_fast    = result < high_lim;
	wire        ot_driven  = r_hold | l_hold | remote_overtemp_flag | local_overtemp_flag;
	// pin low while not driving it means someone outside pulls it; the delayed
	// enables mask the synchroniser lag right after our own release
	wire        ext_ot     = ~sync_q[1] & overtemp_pin_oe_n & oe_d1 & oe_d2;
	wire        wb_go      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        rd_go      = wb_go & ~wb_we_i;
	wire        wr_go      = wb_go & wb_we_i;
	wire        st_read    = rd_go & (wb_adr_i == `FSMON_OFS_STATUS);
	wire        r_over     = ot_over(remote_temp, ot_lims[7:0]);
	wire        l_over     = ot_over(local_temp, ot_lims[15:8]);
	wire        r_under    = ot_clear(remote_temp, ot_lims[7:0]);
	wire        l_under    = ot_clear(local_temp, ot_lims[15:8]);
	wire [25:0] spin_len   = spin_units(spinup_time_sel) * SPIN_UNIT_TICKS[19:0];

	// effective duty: overtemp forcing, then floors and cut-offs
	reg  [7:0]  next_duty;
	always @* begin
		next_duty = duty_cycle_setting;
		if (ext_ot | (ot_driven & overtemp_full_speed_en))
			next_duty = `FSMON_DUTY_FULL;
		else if (~pwr_mode & is_reg & (duty_cycle_setting < `FSMON_DUTY_30))
			next_duty = `FSMON_DUTY_30;
		else if (low_duty)
			next_duty = 8'h00;
	end

	// read data mux
	reg  [31:0] next_rdata;
	always @* begin
		next_rdata = 32'h0;
		case (wb_adr_i)
			`FSMON_OFS_CFG:      next_rdata = {16'h0, cfg};
			`FSMON_OFS_DUTY:     next_rdata = {24'h0, duty_cycle_setting};
			`FSMON_OFS_SPD_LO:   next_rdata = {24'h0, speed_period[7:0]};
			`FSMON_OFS_SPD_HI:   next_rdata = {24'h0, hi_frozen ? hi_snap : speed_period[15:8]};
			`FSMON_OFS_LOW_LIM:  next_rdata = {16'h0, low_lim};
			`FSMON_OFS_HIGH_LIM: next_rdata = {16'h0, high_lim};
			`FSMON_OFS_STATUS:   next_rdata = {26'h0, fan_fail, ext_ot, local_overtemp_flag,
			                                   remote_overtemp_flag, overspeed_flag, fan_slow};
			`FSMON_OFS_OT_LIM:   next_rdata = {16'h0, ot_lims};
			`FSMON_OFS_DUTY_OUT: next_rdata = {24'h0, duty_out};
			default:             next_rdata = 32'h0;
		endcase
	end

	// ****************************************
	// wishbone slave and software registers
	// ****************************************
	// merged write words; only the low half lands in the 16-bit registers
	wire [31:0] cfg_wr  = wmerge({16'h0, cfg}, wb_dat_i, wb_sel_i);
	wire [31:0] low_wr  = wmerge({16'h0, low_lim}, wb_dat_i, wb_sel_i);
	wire [31:0] high_wr = wmerge({16'h0, high_lim}, wb_dat_i, wb_sel_i);
	wire [31:0] ot_wr   = wmerge({16'h0, ot_lims}, wb_dat_i, wb_sel_i);

	// one wait state: ack follows the request edge, then drops for a cycle
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o           <= 1'b0;
			wb_dat_o           <= 32'h0;
			cfg                <= `FSMON_CFG_RST;
			duty_cycle_setting <= 8'h00;
			low_lim            <= `FSMON_LOW_LIM_RST;
			high_lim           <= `FSMON_HIGH_LIM_RST;
			ot_lims            <= `FSMON_OT_LIM_RST;
			hi_snap            <= 8'h00;
			hi_frozen          <= 1'b0;
		end else if (ce) begin
			wb_ack_o <= wb_go;
			if (rd_go)
				wb_dat_o <= next_rdata;
			// low byte read catches the high byte; high byte read releases it
			if (rd_go & (wb_adr_i == `FSMON_OFS_SPD_LO)) begin
				hi_snap   <= speed_period[15:8];
				hi_frozen <= 1'b1;
			end else if (rd_go & (wb_adr_i == `FSMON_OFS_SPD_HI)) begin
				hi_frozen <= 1'b0;
			end
			if (wr_go) begin
				case (wb_adr_i)
					`FSMON_OFS_CFG:      cfg <= cfg_wr[15:0];
					`FSMON_OFS_DUTY:     duty_cycle_setting <= wb_sel_i[0] ? wb_dat_i[7:0]
					                                                    : duty_cycle_setting;
					`FSMON_OFS_LOW_LIM:  low_lim  <= low_wr[15:0];
					`FSMON_OFS_HIGH_LIM: high_lim <= high_wr[15:0];
					`FSMON_OFS_OT_LIM:   ot_lims  <= ot_wr[15:0];
					default: ;   // read-only or unmapped: ignored
				endcase
			end
		end
	end

	// ****************************************
	// 100 kHz tick and speed period measurement
	// ****************************************
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt  <= 12'h000;
			tick     <= 1'b0;
			tach_d   <= 1'b1;
			mon_cnt  <= 20'h00000;
			meas_st  <= M_WAIT;
			edge_cnt <= 3'h0;
			per_cnt  <= 16'h0000;
			force_on <= 1'b0;
		end else if (ce) begin
			tach_d  <= sync_q[0];
			tick    <= (div_cnt == TICK_DIV - 12'h1);
			div_cnt <= (div_cnt == TICK_DIV - 12'h1) ? 12'h000 : div_cnt + 12'h1;
			// stopped or spinning: hold the window at its start
			if (~monitoring | spinup_active) begin
				mon_cnt  <= 20'h00000;
				meas_st  <= M_WAIT;
				edge_cnt <= 3'h0;
				per_cnt  <= 16'h0000;
			end else if (mon_end) begin
				mon_cnt  <= 20'h00000;
				meas_st  <= M_WAIT;
				edge_cnt <= 3'h0;
				per_cnt  <= 16'h0000;
			end else begin
				if (tick)
					mon_cnt <= mon_cnt + 20'h1;
				case (meas_st)
					M_WAIT: if (tach_rise) begin
						meas_st <= M_CNT;
					end
					M_CNT: begin
						// a stalled count stays at full scale rather than wrapping
						if (tick & (per_cnt != 16'hFFFF))
							per_cnt <= per_cnt + 16'h1;
						if (tach_rise) begin
							edge_cnt <= edge_cnt + 3'h1;
							if (edge_cnt + 3'h1 == edge_tgt)
								meas_st <= M_DONE;
						end
					end
					M_DONE: meas_st <= M_DONE;
					default: meas_st <= M_WAIT;
				endcase
			end
			// hold drive on across the counted edges unless power mode is set
			force_on <= ~pwr_mode & monitoring & ~spinup_active &
			            (meas_st != M_DONE);
		end
	end

	// ****************************************
	// result, fan alarms, spin-up and failure
	// ****************************************
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			speed_period   <= 16'h0000;
			fan_slow       <= 1'b0;
			overspeed_flag <= 1'b0;
			ovs_armed      <= 1'b1;
			spinup_active  <= 1'b0;
			spin_cnt       <= 26'h0;
			spin_tries     <= 3'h0;
			fan_fail       <= 1'b0;
		end else if (ce) begin
			if (upd)
				speed_period <= result;
			// slow flag: a set in the read cycle wins over the clear
			if (upd & is_slow)
				fan_slow <= 1'b1;
			else if (spinup_active & tick & (spin_cnt == 26'h1))
				fan_slow <= 1'b1;
			else if (st_read)
				fan_slow <= 1'b0;
			// overspeed sets once, then waits for the speed to fall back
			if (upd & is_fast & ovs_armed) begin
				overspeed_flag <= 1'b1;
				ovs_armed      <= 1'b0;
			end else begin
				if (st_read)
					overspeed_flag <= 1'b0;
				if (upd & ~is_fast)
					ovs_armed <= 1'b1;
			end
			// spin-up timer; on expiry monitoring restarts at once
			if (spinup_active) begin
				if (~spin_en | ~monitoring) begin
					spinup_active <= 1'b0;
					spin_cnt      <= 26'h0;
				end else if (tick) begin
					spin_cnt <= spin_cnt - 26'h1;
					if (spin_cnt == 26'h1)
						spinup_active <= 1'b0;
				end
			end else if (upd & is_slow & spin_en) begin
				spinup_active <= 1'b1;
				spin_cnt      <= spin_len;
				if (spin_tries == `FSMON_SPIN_TRIES)
					fan_fail <= 1'b1;
				else
					spin_tries <= spin_tries + 3'h1;
			end else if (upd & ~is_slow) begin
				spin_tries <= 3'h0;
				fan_fail   <= 1'b0;
			end
		end
	end

	// ****************************************
	// overtemp pin, flags and hysteresis
	// ****************************************
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_hold               <= 1'b0;
			l_hold               <= 1'b0;
			r_armed              <= 1'b1;
			l_armed              <= 1'b1;
			remote_overtemp_flag <= 1'b0;
			local_overtemp_flag  <= 1'b0;
		end else if (ce) begin
			// pin hold: set over limit, release only 5 degrees below it
			if (r_over)
				r_hold <= 1'b1;
			else if (r_under)
				r_hold <= 1'b0;
			if (l_over)
				l_hold <= 1'b1;
			else if (l_under)
				l_hold <= 1'b0;
			// flag once per excursion; a read does not release the pin while a hold is set
			if (r_over & r_armed) begin
				remote_overtemp_flag <= 1'b1;
				r_armed              <= 1'b0;
			end else begin
				if (st_read)
					remote_overtemp_flag <= 1'b0;
				if (r_under)
					r_armed <= 1'b1;
			end
			if (l_over & l_armed) begin
				local_overtemp_flag <= 1'b1;
				l_armed             <= 1'b0;
			end else begin
				if (st_read)
					local_overtemp_flag <= 1'b0;
				if (l_under)
					l_armed <= 1'b1;
			end
		end
	end

	// ****************************************
	// output flops
	// ****************************************
	// open-drain pins drive zero; the enable alone decides the level
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			overtemp_pin_o    <= 1'b0;
			overtemp_pin_oe_n <= 1'b1;
			fault_o           <= 1'b0;
			fault_oe_n        <= 1'b1;
			alert_o           <= 1'b0;
			alert_oe_n        <= 1'b1;
			duty_out          <= 8'h00;
			oe_d1             <= 1'b1;
			oe_d2             <= 1'b1;
		end else if (ce) begin
			oe_d1             <= overtemp_pin_oe_n;
			oe_d2             <= oe_d1;
			overtemp_pin_oe_n <= ~(r_hold | l_hold | remote_overtemp_flag |
			                       local_overtemp_flag);
			fault_oe_n        <= ~(fault_en & fan_fail);
			alert_oe_n        <= ~((fan_range_irq_en & (fan_slow | overspeed_flag)) |
			                       (overtemp_irq_en & (remote_overtemp_flag |
			                                           local_overtemp_flag)));
			duty_out          <= next_duty;
		end
	end

endmodule

`default_nettype wire

// *** tb/fsmon_top_asserts.sv ***
// port checks for the fan speed monitor, bound into its top module
`default_nettype none
module fsmon_chk (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic [7:0]  remote_temp,
	input wire logic [7:0]  local_temp,
	input wire logic        overtemp_pin_i,
	input wire logic        overtemp_pin_o,
	input wire logic        overtemp_pin_oe_n,
	input wire logic        fault_o,
	input wire logic        alert_o,
	input wire logic [7:0]  duty_out
);
	// one domain, so clock and reset are declared once
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// request waiting for its answer
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	// a temperature above the reset limit of 100
	sequence s_hot; $signed(remote_temp) > 100 || $signed(local_temp) > 100; endsequence
	// wire low while the device itself is not pulling
	sequence s_ext; !overtemp_pin_i && overtemp_pin_oe_n; endsequence
	AST_ACK_ONE: assert property (s_req |=> wb_ack_o)
		else $error("ack late");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_DAT_HOLD: assert property (!wb_ack_o |-> $stable(wb_dat_o))
		else $error("read data moved");
	AST_OT_SET: assert property (s_hot |-> ##[1:2] !overtemp_pin_oe_n)
		else $error("overtemp pin not pulled");
	AST_OT_HOLD: assert property (!overtemp_pin_oe_n && ($signed(remote_temp) > 95
		|| $signed(local_temp) > 95) |=> !overtemp_pin_oe_n) else $error("pin released early");
	AST_EXT_FULL: assert property (s_ext [*5] |-> duty_out == 8'hFF)
		else $error("no full duty");
	AST_OD_ZERO: assert property (!(overtemp_pin_o | fault_o | alert_o))
		else $error("open drain drives high");
endmodule
bind fsmon_top fsmon_chk chk_u (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
	.remote_temp, .local_temp, .overtemp_pin_i, .overtemp_pin_o, .overtemp_pin_oe_n, .fault_o,
	.alert_o, .duty_out);
`default_nettype wire

// *** tb/fsmon_fan.sv ***
// fan model: speed pulses and an outside party on the pulled-up overtemp wire
`default_nettype none
module fsmon_fan #(
	parameter int HALF = 1000
) (
	input  wire logic ref_clk,
	input  wire logic spin,
	input  wire logic pull_req,
	input  wire logic dev_oe_n,
	output wire logic tach,
	output wire logic wire_lvl
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt; // clocks since the last pulse edge
	logic tq = 1'b0; // pulse level, low before the first edge
	// a stopped fan leaves its pulse line low, not at the last level
	always @(posedge ref_clk) begin
		cnt <= (cnt >= HALF - 1) ? 0 : cnt + 1;
		if (cnt >= HALF - 1)
			tq <= spin & ~tq;
	end
	assign tach = tq;
	// pull-up: low when either party pulls
	assign wire_lvl = ~(pull_req | ~dev_oe_n);
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the fan speed monitor
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        ref_clk, rst_n, cyc, stb, we, ack, spin, pull, pin, tach, ot_n, al_n;
	logic        ce, fo_n, f_on, spin_on; // enable, failure pin, drive hold, spin-up
	logic [7:0]  adr, rtemp, ltemp;
	logic [31:0] wdat, rdat, d, g, lo_v, hi_v;
	logic [31:0] q_lo[$], q_hi[$], q_m[$]; // expected window and mask per read
	int          n_errors, checks_done, cycles;
	fsmon_top #(.MON_SLOW_TICKS(8), .MON_FAST_TICKS(6), .SPIN_UNIT_TICKS(2)) dut_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
		.wb_ack_o(ack), .tach_i(tach), .remote_temp(rtemp), .local_temp(ltemp),
		.overtemp_pin_i(pin), .overtemp_pin_o(), .overtemp_pin_oe_n(ot_n), .fault_o(),
		.fault_oe_n(fo_n), .alert_o(), .alert_oe_n(al_n), .duty_out(), .force_on(f_on),
		.spinup_active(spin_on));
	fsmon_fan #(.HALF(1000)) fan_u (.ref_clk(ref_clk), .spin(spin), .pull_req(pull),
		.dev_oe_n(ot_n), .tach(tach), .wire_lvl(pin));
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// classic cycle: hold everything until ack is seen at a rising edge
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v);
		@(posedge ref_clk);
		adr <= a;
		we <= w;
		wdat <= v;
		cyc <= 1'b1;
		stb <= 1'b1;
		do @(posedge ref_clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// note the expected window before the read is issued
	task automatic rd(input logic [7:0] a, input logic [31:0] lo, hi, m = 32'hFFFFFFFF);
		q_lo.push_back(lo);
		q_hi.push_back(hi);
		q_m.push_back(m);
		bus(a, 1'b0, 32'h0);
	endtask
	task automatic chk(input logic v, input logic e);
		checks_done++;
		if (v !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, v, e);
		end
		@(posedge ref_clk); // back on the driving edge
	endtask
	task automatic final_report;
		$display("errors=%0d checks=%0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// read answers are matched against the oldest note
	always @(posedge ref_clk) begin
		if (ack === 1'b1 && we === 1'b0 && q_m.size() > 0) begin
			g = rdat & q_m.pop_front();
			lo_v = q_lo.pop_front();
			hi_v = q_hi.pop_front();
			checks_done++;
			if ((g >= lo_v && g <= hi_v) !== 1'b1) begin
				n_errors++;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, g, lo_v);
			end
		end
	end
	// a hang counts as a failure
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 90000) begin
			n_errors++;
			final_report();
		end
	end
	initial begin
		void'($urandom(32'h74ED));
		{rst_n, cyc, stb, we, spin, pull, adr, wdat} = '0;
		rtemp = 8'h19;
		ltemp = 8'($urandom_range(60));
		ce = 1'b1;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(8'h00, 32'h5800, 32'h5800);
		rd(8'h10, 32'hFFFF, 32'hFFFF);
		rd(8'h14, 32'h0, 32'h0);
		rd(8'h1C, 32'h6464, 32'h6464);
		rd(8'h3C, 32'h0, 32'h0);
		d = $urandom_range(8'h11, 8'h01);
		bus(8'h04, 1'b1, d);
		bus(8'h00, 1'b1, 32'h5A0F);
		rd(8'h20, d, d);
		bus(8'h00, 1'b1, 32'h5A0B);
		rd(8'h20, 32'h0, 32'h0);
		bus(8'h00, 1'b1, 32'h560B);
		bus(8'h20, 1'b1, 32'hFF);
		rd(8'h20, 32'h4D, 32'h4D);
		bus(8'h14, 1'b1, 32'h10);
		spin <= 1'b1;
		bus(8'h00, 1'b1, 32'h5A2F);
		repeat (24000) @(posedge ref_clk);
		@(negedge ref_clk) chk(al_n, 1'b0);
		rd(8'h08, 32'h1, 32'h3, 32'hFF);
		rd(8'h0C, 32'h0, 32'h0, 32'hFF);
		rd(8'h18, 32'h2, 32'h2, 32'h3F);
		rd(8'h18, 32'h0, 32'h0, 32'h3F);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk) chk(al_n, 1'b1);
		bus(8'h00, 1'b1, 32'h5A3F);
		repeat (24000) @(posedge ref_clk);
		rd(8'h08, 32'h3, 32'h5, 32'hFF);
		rtemp <= 8'd101;
		repeat (4) @(posedge ref_clk);
		rd(8'h18, 32'h4, 32'h4, 32'hF);
		rd(8'h18, 32'h0, 32'h0, 32'hF);
		@(negedge ref_clk) chk(ot_n, 1'b0);
		rtemp <= 8'd95;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk) chk(ot_n, 1'b1);
		pull <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rd(8'h18, 32'h10, 32'h10, 32'h10);
		rd(8'h20, 32'hFF, 32'hFF);
		// a stopped fan reads slow and, with spin-up on, starts a spin-up
		pull <= 1'b0;
		spin <= 1'b0;
		bus(8'h10, 1'b1, 32'h100);
		bus(8'h00, 1'b1, 32'h050B);
		while (spin_on !== 1'b1) @(posedge ref_clk);
		@(negedge ref_clk) chk(fo_n, 1'b1);
		rd(8'h18, 32'h1, 32'h1, 32'h21);
		rd(8'h18, 32'h0, 32'h0, 32'h21);
		while (spin_on === 1'b1) @(posedge ref_clk);
		@(negedge ref_clk) chk(f_on, 1'b1);
		rd(8'h18, 32'h1, 32'h1, 32'h1);
		// let the watcher take the last answer before the verdict
		repeat (2) @(posedge ref_clk);
		final_report();
	end
endmodule
`default_nettype wire
